// file: rsbs_reset_boot.sv
// Purpose: Reset combining, watchdog, software reset, cause flags, boot select
// Assumes: Watchdog clock arrives as a tick pin; Wishbone classic slave
// Notes:   Core must stop at the edge after o_ctrl.core_reset rises
//
// How it works
// R01: Watchdog counts synchronised ticks of its own clock, limit set by prescale.
// R02: Writing the clear bit restarts the watchdog count from zero.
// R03: Timeout plus unanswered grace period resets whole system; PC restarts at 0000H.
// R04: Watchdog cause flag bit 3, set by watchdog reset, kept otherwise, clearable.
// R05: Writing 1 to chip control bit 7 starts a full system reset.
// R06: Protected writes need 0AAh then 55h to timed access, interrupts off.
// R07: Core reset rises right after the edge taking the software reset write.
// R08: Software reset request bit reads zero and clears when reset ends.
// R09: Software cause flag bit 7, set by software reset, kept otherwise.
// R10: Boot select bit 1: 0 application flash, 1 loader flash.
// R11: Non-software resets load boot select with inverted configuration boot bit.
// R12: Configuration boot bit 7: 1 application, 0 loader; byte resets to FFh.
// R13: Boot region on release follows current boot select bit only.
// R14: RAM keep flag low only after power-on reset.
// R15: Program counter forced to 0000H while reset holds.
// R16: Stack pointer loaded with 07H by every reset.
// R17: Peripherals and interrupts disabled by every reset.
// R18: Port latches FFH and input-only mode after every reset.
// R19: Power-on sets power-on flag bit 4 of power control register.
// R20: All requests merge into one synchronous reset; flags follow own source only.

`timescale 1ns/1ns

module rsbs_reset_boot #(
    parameter int WD_GRACE_TICKS = 64
) (
    // Clock and reset
    input  wire logic                      i_sys_clk,
    input  wire logic                      i_nrst,
    // Wishbone slave
    input  wire logic                      i_wb_cyc,
    input  wire logic                      i_wb_stb,
    input  wire logic                      i_wb_we,
    input  wire logic [9:0]                i_wb_adr,
    input  wire logic [3:0]                i_wb_sel,
    input  wire logic [31:0]               i_wb_dat,
    output logic      [31:0]               o_wb_dat,
    output logic                           o_wb_ack,
    // Reset sources and core status
    input  wire logic                      i_ext_rst_n,
    input  wire logic                      i_wd_tick,
    input  wire logic                      i_other_rst_req,
    input  wire logic                      i_irq_en,
    // Core reset controls
    output rsbs_pkg::rsbs_core_ctrl_t      o_ctrl
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam int GW = $clog2(WD_GRACE_TICKS + 1);

    rsbs_pkg::rsbs_state_t     state_reg;
    rsbs_pkg::rsbs_cause_t     cause_reg;
    rsbs_pkg::rsbs_cause_t     req;
    rsbs_pkg::rsbs_core_ctrl_t ctrl_reg;
    logic [3:0]  hold_cnt_reg;
    logic        ext_s1_reg, ext_s2_reg;
    logic        tick_s1_reg, tick_s2_reg, tick_s3_reg;
    logic [7:0]  cc_reg, aux_reg, wd_reg, pwr_reg, cfg_reg;
    logic        ta_first_reg;
    logic [2:0]  ta_open_reg;
    logic [15:0] wd_cnt_reg;
    logic [GW-1:0] wd_grace_reg;
    logic        wd_armed_reg, wd_expired_reg;
    logic        ack_reg;
    logic [31:0] dat_reg;
    logic        wr_now, prot_ok, wr_cc, wr_aux, wr_wd, wr_pwr, wr_cfg, wr_ta;
    logic        any_req, entry, leave, wd_tick, wd_clr, wd_timeout;
    logic [7:0]  idx, wdat, rdat;

    function automatic logic [15:0] wd_limit(input logic [2:0] ps);
        wd_limit = (rsbs_pkg::WD_BASE_LIMIT << ps) - 16'h0001;
    endfunction

    // ------------------------------------------------------------
    // Synchronisers for pin inputs
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            ext_s1_reg <= 1'b1;
            ext_s2_reg <= 1'b1;
        end else begin
            ext_s1_reg <= i_ext_rst_n;
            ext_s2_reg <= ext_s1_reg;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            tick_s1_reg <= 1'b0;
            tick_s2_reg <= 1'b0;
            tick_s3_reg <= 1'b0;
        end else begin
            tick_s1_reg <= i_wd_tick;
            tick_s2_reg <= tick_s1_reg;
            tick_s3_reg <= tick_s2_reg;
        end
    end

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    assign idx     = i_wb_adr[9:2];
    assign wdat    = i_wb_dat[7:0];
    assign wr_now  = i_wb_cyc & i_wb_stb & ack_reg & i_wb_we & i_wb_sel[0];
    assign prot_ok = (ta_open_reg != 3'h0) & ~i_irq_en; // [R06]
    assign wr_cc   = wr_now & (idx == rsbs_pkg::IDX_CHIP_CTRL) & prot_ok; // [R06]
    assign wr_wd   = wr_now & (idx == rsbs_pkg::IDX_WD_CTRL) & prot_ok; // [R06]
    assign wr_aux  = wr_now & (idx == rsbs_pkg::IDX_AUX_ONE);
    assign wr_pwr  = wr_now & (idx == rsbs_pkg::IDX_PWR_CTRL);
    assign wr_cfg  = wr_now & (idx == rsbs_pkg::IDX_BOOT_CFG);
    assign wr_ta   = wr_now & (idx == rsbs_pkg::IDX_TIMED_ACC);

    always_comb begin
        unique case (idx)
            rsbs_pkg::IDX_CHIP_CTRL: rdat = cc_reg & rsbs_pkg::CC_WR_MASK; // [R08]
            rsbs_pkg::IDX_AUX_ONE:   rdat = aux_reg;
            rsbs_pkg::IDX_WD_CTRL:   rdat = wd_reg;
            rsbs_pkg::IDX_PWR_CTRL:  rdat = pwr_reg;
            rsbs_pkg::IDX_BOOT_CFG:  rdat = cfg_reg;
            default:                 rdat = 8'h00;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= i_wb_cyc & i_wb_stb & ~ack_reg;
            if (i_wb_cyc & i_wb_stb & ~ack_reg) begin
                dat_reg <= {24'h00_0000, rdat};
            end
        end
    end

    // ------------------------------------------------------------
    // Timed access window
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            ta_first_reg <= 1'b0;
            ta_open_reg  <= 3'h0;
        end else if (wr_ta) begin
            ta_first_reg <= (wdat == rsbs_pkg::TA_KEY_FIRST) & ~i_irq_en; // [R06]
            if ((wdat == rsbs_pkg::TA_KEY_SECOND) & ta_first_reg & ~i_irq_en) begin
                ta_open_reg <= rsbs_pkg::TA_OPEN_CYCLES;
            end else begin
                ta_open_reg <= 3'h0;
            end
        end else if (wr_cc | wr_wd) begin
            ta_open_reg <= 3'h0;
        end else if (ta_open_reg != 3'h0) begin
            ta_open_reg <= ta_open_reg - 3'h1;
        end
    end

    // ------------------------------------------------------------
    // Reset combining and sequencing
    // ------------------------------------------------------------
    assign req.sw    = wr_cc & wdat[rsbs_pkg::CC_SOFTWARE_RESET_REQUEST_BIT]; // [R05]
    assign req.wdt   = wd_expired_reg; // [R03]
    assign req.ext   = ~ext_s2_reg;
    assign req.other = i_other_rst_req;
    assign any_req   = req.sw | req.wdt | req.ext | req.other; // [R20]
    assign entry     = (state_reg == rsbs_pkg::RSBS_RUN) & any_req;
    assign leave     = (state_reg == rsbs_pkg::RSBS_HOLD) & (hold_cnt_reg == 4'h0) & ~req.ext;

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            state_reg    <= rsbs_pkg::RSBS_HOLD;
            hold_cnt_reg <= rsbs_pkg::HOLD_CYCLES;
            cause_reg    <= '0;
        end else begin
            unique case (state_reg)
                rsbs_pkg::RSBS_RUN: begin
                    if (any_req) begin
                        state_reg    <= rsbs_pkg::RSBS_HOLD; // [R07]
                        hold_cnt_reg <= rsbs_pkg::HOLD_CYCLES;
                        cause_reg    <= req;
                    end
                end
                rsbs_pkg::RSBS_HOLD: begin
                    if (hold_cnt_reg != 4'h0) begin
                        hold_cnt_reg <= hold_cnt_reg - 4'h1;
                    end else if (leave) begin
                        state_reg <= rsbs_pkg::RSBS_RUN;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Chip control: software reset and boot select
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            cc_reg <= rsbs_pkg::CC_RESET;
            cc_reg[rsbs_pkg::CC_BS_BIT] <= ~rsbs_pkg::CFG_RESET[rsbs_pkg::CFG_CBS_BIT]; // [R11]
        end else if (entry) begin
            cc_reg <= rsbs_pkg::CC_RESET; // [R17]
            cc_reg[rsbs_pkg::CC_SOFTWARE_RESET_REQUEST_BIT] <= req.sw;
            if (req.wdt | req.ext | req.other) begin
                cc_reg[rsbs_pkg::CC_BS_BIT] <= ~cfg_reg[rsbs_pkg::CFG_CBS_BIT]; // [R11] [R12]
            end else begin
                cc_reg[rsbs_pkg::CC_BS_BIT] <= wdat[rsbs_pkg::CC_BS_BIT]; // [R11]
            end
        end else if (leave) begin
            cc_reg[rsbs_pkg::CC_SOFTWARE_RESET_REQUEST_BIT] <= 1'b0; // [R08]
        end else if (wr_cc) begin
            cc_reg <= wdat & rsbs_pkg::CC_WR_MASK; // [R10]
        end
    end

    // ------------------------------------------------------------
    // Cause flags and plain registers
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            aux_reg <= rsbs_pkg::AUX_RESET;
        end else if (entry) begin
            aux_reg <= rsbs_pkg::AUX_RESET;
            aux_reg[rsbs_pkg::AUX_SOFTWARE_RESET_CAUSE_FLAG_BIT] <= aux_reg[rsbs_pkg::AUX_SOFTWARE_RESET_CAUSE_FLAG_BIT] | req.sw; // [R09] [R20]
            aux_reg[rsbs_pkg::AUX_PIN_BIT]  <= aux_reg[rsbs_pkg::AUX_PIN_BIT] | req.ext; // [R20]
        end else if (wr_aux) begin
            aux_reg <= wdat & rsbs_pkg::AUX_WR_MASK;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            pwr_reg <= rsbs_pkg::PWR_RESET; // [R19]
        end else if (entry) begin
            pwr_reg <= pwr_reg & (8'h01 << rsbs_pkg::PWR_POF_BIT); // [R19]
        end else if (wr_pwr) begin
            pwr_reg <= wdat;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            cfg_reg <= rsbs_pkg::CFG_RESET; // [R12]
        end else if (wr_cfg) begin
            cfg_reg <= wdat;
        end
    end

    // ------------------------------------------------------------
    // Watchdog control and counter
    // ------------------------------------------------------------
    assign wd_tick    = tick_s2_reg & ~tick_s3_reg; // [R01]
    assign wd_clr     = wr_wd & wdat[rsbs_pkg::WD_CLR_BIT]; // [R02]
    assign wd_timeout = wd_tick & wd_reg[rsbs_pkg::WD_EN_BIT] & (wd_cnt_reg == wd_limit(wd_reg[2:0])); // [R01]

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            wd_reg <= rsbs_pkg::WD_RESET;
        end else if (entry) begin
            wd_reg <= rsbs_pkg::WD_RESET;
            wd_reg[rsbs_pkg::WD_RF_BIT] <= wd_reg[rsbs_pkg::WD_RF_BIT] | req.wdt; // [R04] [R20]
        end else begin
            if (wr_wd) begin
                wd_reg <= wdat;
                wd_reg[rsbs_pkg::WD_CLR_BIT] <= 1'b0;
            end
            if (wd_timeout) begin
                wd_reg[rsbs_pkg::WD_TF_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            wd_cnt_reg <= 16'h0000;
        end else if (entry | wd_clr | (state_reg == rsbs_pkg::RSBS_HOLD) | ~wd_reg[rsbs_pkg::WD_EN_BIT]) begin
            wd_cnt_reg <= 16'h0000; // [R02]
        end else if (wd_timeout) begin
            wd_cnt_reg <= 16'h0000;
        end else if (wd_tick) begin
            wd_cnt_reg <= wd_cnt_reg + 16'h0001; // [R01]
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            wd_armed_reg   <= 1'b0;
            wd_grace_reg   <= '0;
            wd_expired_reg <= 1'b0;
        end else if (entry | wd_clr | (state_reg == rsbs_pkg::RSBS_HOLD) | ~wd_reg[rsbs_pkg::WD_EN_BIT]) begin
            wd_armed_reg   <= 1'b0;
            wd_expired_reg <= 1'b0;
        end else if (wd_timeout & ~wd_armed_reg) begin
            wd_armed_reg <= 1'b1;
            wd_grace_reg <= GW'(WD_GRACE_TICKS);
        end else if (wd_armed_reg & wd_tick) begin
            if (wd_grace_reg == '0) begin
                wd_expired_reg <= 1'b1; // [R03]
            end else begin
                wd_grace_reg <= wd_grace_reg - GW'(1);
            end
        end
    end

    // ------------------------------------------------------------
    // Core reset controls
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        ctrl_reg.pc         <= rsbs_pkg::PC_RESET; // [R15]
        ctrl_reg.sp         <= rsbs_pkg::SP_RESET; // [R16]
        ctrl_reg.port_latch <= rsbs_pkg::PORT_RESET; // [R18]
        if (!i_nrst) begin
            ctrl_reg.core_reset      <= 1'b1;
            ctrl_reg.boot_loader     <= ~rsbs_pkg::CFG_RESET[rsbs_pkg::CFG_CBS_BIT];
            ctrl_reg.ram_keep        <= 1'b0; // [R14]
            ctrl_reg.port_input_only <= 1'b1;
            ctrl_reg.periph_off      <= 1'b1;
        end else begin
            ctrl_reg.core_reset      <= entry | ((state_reg == rsbs_pkg::RSBS_HOLD) & ~leave); // [R20]
            ctrl_reg.port_input_only <= entry | ((state_reg == rsbs_pkg::RSBS_HOLD) & ~leave); // [R18]
            ctrl_reg.periph_off      <= entry | ((state_reg == rsbs_pkg::RSBS_HOLD) & ~leave); // [R17]
            if (state_reg == rsbs_pkg::RSBS_HOLD) begin
                ctrl_reg.boot_loader <= cc_reg[rsbs_pkg::CC_BS_BIT]; // [R13]
            end
            if (entry) begin
                ctrl_reg.ram_keep <= 1'b1; // [R14]
            end
        end
    end

    assign o_ctrl   = ctrl_reg;
    assign o_wb_ack = ack_reg;
    assign o_wb_dat = dat_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);

    AST_SW_RESET_NOW: assert property (req.sw |=> o_ctrl.core_reset) // [R05] [R07]
        else $error("software reset did not assert core reset");
    AST_TA_REFUSE: assert property (wr_now & (idx == rsbs_pkg::IDX_CHIP_CTRL) & ~prot_ok
                                    & (state_reg == rsbs_pkg::RSBS_RUN) & ~any_req
                                    |=> state_reg == rsbs_pkg::RSBS_RUN) // [R06]
        else $error("unprotected write caused a reset");
    AST_HOLD_LEN: assert property ($rose(o_ctrl.core_reset) |-> o_ctrl.core_reset [*8]) // [R20]
        else $error("core reset shorter than hold count");
    AST_PC_SP: assert property (o_ctrl.core_reset |-> (o_ctrl.pc == 16'h0000) && (o_ctrl.sp == 8'h07)) // [R15] [R16]
        else $error("pc or sp wrong during reset");
    AST_PORTS: assert property (o_ctrl.core_reset |-> o_ctrl.port_latch == 8'hFF && o_ctrl.port_input_only
                                && o_ctrl.periph_off) // [R17] [R18]
        else $error("ports or peripherals not in reset state");
    AST_SOFTWARE_RESET_CAUSE_FLAG_SET: assert property (entry & req.sw |=> aux_reg[7]) // [R09]
        else $error("software cause flag not set");
    AST_WATCHDOG_RESET_CAUSE_FLAG_KEEP: assert property (entry & ~req.wdt |=> wd_reg[3] == $past(wd_reg[3])) // [R04]
        else $error("watchdog flag changed by other reset");
    AST_WATCHDOG_RESET_CAUSE_FLAG_SET: assert property (entry & req.wdt |=> wd_reg[3]) // [R04]
        else $error("watchdog flag not set");
    AST_BS_LOAD: assert property (entry & (req.wdt | req.ext | req.other)
                                  |=> cc_reg[1] == ~$past(cfg_reg[7])) // [R11] [R12]
        else $error("boot select not loaded from configuration");
    AST_BOOT_REGION: assert property ($fell(o_ctrl.core_reset) |-> o_ctrl.boot_loader == cc_reg[1]) // [R13] [R10]
        else $error("boot region differs from boot select");
    AST_SOFTWARE_RESET_REQUEST_CLR: assert property ($fell(o_ctrl.core_reset) |-> !cc_reg[7]) // [R08]
        else $error("software reset bit not cleared");
    AST_WD_RESET: assert property (wd_expired_reg & (state_reg == rsbs_pkg::RSBS_RUN)
                                   |=> o_ctrl.core_reset ##1 o_ctrl.pc == 16'h0000) // [R03]
        else $error("watchdog expiry did not reset");
    AST_WD_CLEAR: assert property (wd_clr |=> wd_cnt_reg == 16'h0000 && !wd_armed_reg) // [R02]
        else $error("watchdog clear did not restart count");

    COV_SW_RESET:  cover property (req.sw ##[1:20] $fell(o_ctrl.core_reset));
    COV_WD_RESET:  cover property (wd_timeout ##[1:1000] entry & req.wdt);
    COV_EXT_RESET: cover property (entry & req.ext);
    COV_LOADER:    cover property ($fell(o_ctrl.core_reset) & o_ctrl.boot_loader);

endmodule

// file: rsbs_pkg.sv
// Purpose: Shared constants and types of the reset source and boot select block
// Assumes: Register indices are byte address divided by four
// Notes:   One 8-bit register per 32-bit word, data in the low byte

package rsbs_pkg;
    // ------------------------------------------------------------
    // Register indices
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_PWR_CTRL  = 8'h87;
    localparam logic [7:0] IDX_CHIP_CTRL = 8'h9F;
    localparam logic [7:0] IDX_AUX_ONE   = 8'hA2;
    localparam logic [7:0] IDX_WD_CTRL   = 8'hAA;
    localparam logic [7:0] IDX_TIMED_ACC = 8'hC0;
    localparam logic [7:0] IDX_BOOT_CFG  = 8'hF0;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CC_SOFTWARE_RESET_REQUEST_BIT = 7;
    localparam int CC_BS_BIT    = 1;
    localparam int AUX_SOFTWARE_RESET_CAUSE_FLAG_BIT = 7;
    localparam int AUX_PIN_BIT  = 6;
    localparam int WD_EN_BIT    = 7;
    localparam int WD_CLR_BIT   = 6;
    localparam int WD_TF_BIT    = 5;
    localparam int WD_RF_BIT    = 3;
    localparam int CFG_CBS_BIT  = 7;
    localparam int PWR_POF_BIT  = 4;

    // ------------------------------------------------------------
    // Write masks and values after reset
    // ------------------------------------------------------------
    localparam logic [7:0] CC_WR_MASK  = 8'h43;
    localparam logic [7:0] AUX_WR_MASK = 8'hF9;
    localparam logic [7:0] CC_RESET    = 8'h00;
    localparam logic [7:0] AUX_RESET   = 8'h00;
    localparam logic [7:0] WD_RESET    = 8'h07;
    localparam logic [7:0] PWR_RESET   = 8'h10;
    localparam logic [7:0] CFG_RESET   = 8'hFF;
    localparam logic [15:0] PC_RESET   = 16'h0000;
    localparam logic [7:0] SP_RESET    = 8'h07;
    localparam logic [7:0] PORT_RESET  = 8'hFF;

    // ------------------------------------------------------------
    // Timed access and sequencing counts
    // ------------------------------------------------------------
    localparam logic [7:0] TA_KEY_FIRST   = 8'hAA;
    localparam logic [7:0] TA_KEY_SECOND  = 8'h55;
    localparam logic [2:0] TA_OPEN_CYCLES = 3'h4;
    localparam logic [3:0] HOLD_CYCLES    = 4'h8;
    localparam logic [15:0] WD_BASE_LIMIT = 16'h0040;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic {RSBS_RUN, RSBS_HOLD} rsbs_state_t;

    typedef struct packed {
        logic sw;
        logic wdt;
        logic ext;
        logic other;
    } rsbs_cause_t;

    typedef struct packed {
        logic        core_reset;
        logic        boot_loader;
        logic        ram_keep;
        logic [15:0] pc;
        logic [7:0]  sp;
        logic [7:0]  port_latch;
        logic        port_input_only;
        logic        periph_off;
    } rsbs_core_ctrl_t;
endpackage

// file: rsbs_core_model.sv
// Purpose: Core-side partner of the reset block
// Assumes: Core stops at once while core_reset is high
// Notes:   Records the boot region seen at each release
`timescale 1ns/1ns

module rsbs_core_model (
    // Clock
    input  wire logic                      i_sys_clk,
    // Controls from block and bench
    input  wire rsbs_pkg::rsbs_core_ctrl_t i_ctrl,
    input  wire logic                      i_irq_on,
    // Core status
    output logic                           o_irq_en,
    output logic                           o_boot_loader
);
    // Interrupts off while reset holds
    always_ff @(posedge i_sys_clk) begin
        o_irq_en <= i_ctrl.core_reset ? 1'b0 : i_irq_on;
    end

    // Fetch region taken from the block at release
    always_ff @(posedge i_sys_clk) begin
        if (i_ctrl.core_reset) begin
            o_boot_loader <= i_ctrl.boot_loader;
        end
    end
endmodule

// file: test_reset_source_and_boot_select.sv
// Purpose: Bench for reset sources and boot select
// Assumes: Grace of two ticks, one tick per six clocks
// Notes:   Register access through Wishbone classic tasks
`timescale 1ns/1ns

module test_reset_source_and_boot_select;
    localparam logic [7:0] PW = rsbs_pkg::IDX_PWR_CTRL;
    localparam logic [7:0] CC = rsbs_pkg::IDX_CHIP_CTRL;
    localparam logic [7:0] AX = rsbs_pkg::IDX_AUX_ONE;
    localparam logic [7:0] WD = rsbs_pkg::IDX_WD_CTRL;
    localparam logic [7:0] CF = rsbs_pkg::IDX_BOOT_CFG;
    logic                      clk     = 1'b0;
    logic                      nrst    = 1'b0;
    logic                      cyc     = 1'b0;
    logic                      we      = 1'b0;
    logic [9:0]                adr     = 10'h000;
    logic [31:0]               dat     = 32'h0000_0000;
    logic                      ext_n   = 1'b1;
    logic                      tick    = 1'b0;
    logic                      tick_on = 1'b0;
    logic [1:0]                div     = 2'h0;
    logic                      oth     = 1'b0;
    logic                      irq_on  = 1'b0;
    logic [31:0]               rdat;
    logic [31:0]               odat;
    logic                      ack;
    logic                      irq_en;
    logic                      boot;
    rsbs_pkg::rsbs_core_ctrl_t ctrl;
    int                        error_cnt = 0;
    int                        n_tests   = 0;
    int                        cycles    = 0;

    always #10 clk = ~clk;

    rsbs_reset_boot #(.WD_GRACE_TICKS(2)) u_rsbs_reset_boot (
        .i_sys_clk(clk), .i_nrst(nrst), .i_wb_cyc(cyc), .i_wb_stb(cyc), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_sel(4'h1), .i_wb_dat(dat), .o_wb_dat(odat), .o_wb_ack(ack),
        .i_ext_rst_n(ext_n), .i_wd_tick(tick), .i_other_rst_req(oth), .i_irq_en(irq_en),
        .o_ctrl(ctrl));

    rsbs_core_model u_rsbs_core_model (
        .i_sys_clk(clk), .i_ctrl(ctrl), .i_irq_on(irq_on), .o_irq_en(irq_en), .o_boot_loader(boot));

    // Watchdog clock: one tick per six system clocks
    always @(posedge clk) begin
        div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
        if (tick_on && div == 2'h2) begin
            tick <= ~tick;
        end
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            error_cnt++;
            conclude();
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
        we  <= w;
        adr <= {idx, 2'b00};
        dat <= {24'h00_0000, d};
        cyc <= 1'b1;
        do @(posedge clk); while (ack !== 1'b1);
        rdat = odat;
        cyc <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input string nm, input logic [7:0] idx, input logic [7:0] e, input logic [7:0] m);
        bus(1'b0, idx, 8'h00);
        chk(nm, {24'h00_0000, e}, rdat & {24'h00_0000, m});
    endtask

    task automatic ta_wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, 8'hC0, 8'hAA);
        bus(1'b1, 8'hC0, 8'h55);
        bus(1'b1, idx, d);
    endtask

    task automatic wait_rst(input logic lvl);
        for (int k = 0; k < 2000 && ctrl.core_reset !== lvl; k++) @(posedge clk);
        chk("core_reset", 32'(lvl), 32'(ctrl.core_reset));
    endtask

    task automatic chk_load();
        chk("pc", 32'h0000_0000, 32'(ctrl.pc));
        chk("sp", 32'h0000_0007, 32'(ctrl.sp));
        chk("port", 32'h0000_00FF, 32'(ctrl.port_latch));
        chk("input_only", 32'h0000_0001, 32'(ctrl.port_input_only));
        chk("periph_off", 32'h0000_0001, 32'(ctrl.periph_off));
    endtask

    task automatic conclude();
        $display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        chk_load();
        chk("ram_keep", 32'h0000_0000, 32'(ctrl.ram_keep));
        rd("pwr", PW, 8'h10, 8'hFF);
        rd("chip", CC, 8'h00, 8'hFF);
        rd("aux", AX, 8'h00, 8'hFF);
        rd("wdog", WD, 8'h07, 8'hFF);
        rd("cfg", CF, 8'hFF, 8'hFF);
        rd("unmapped", 8'h10, 8'h00, 8'hFF);
        wait_rst(1'b0);
        chk("boot", 32'h0000_0000, 32'(boot));
        bus(1'b1, WD, 8'h80);
        rd("wdog no key", WD, 8'h07, 8'hFF);
        irq_on <= 1'b1;
        repeat (2) @(posedge clk);
        ta_wr(WD, 8'h80);
        irq_on <= 1'b0;
        rd("wdog irq on", WD, 8'h07, 8'hFF);
        $display("Test reset values and key done");
        bus(1'b1, PW, 8'h00);
        bus(1'b1, CF, 8'h7F);
        ta_wr(CC, 8'h80);
        chk("sw prompt", 32'h0000_0001, 32'(ctrl.core_reset));
        chk_load();
        wait_rst(1'b0);
        chk("boot sw", 32'h0000_0000, 32'(boot));
        chk("ram_keep sw", 32'h0000_0001, 32'(ctrl.ram_keep));
        rd("chip sw", CC, 8'h00, 8'hFF);
        rd("aux sw", AX, 8'h80, 8'hFF);
        rd("pwr sw", PW, 8'h00, 8'hFF);
        $display("Test software reset done");
        ext_n <= 1'b0;
        repeat (6) @(posedge clk);
        ext_n <= 1'b1;
        wait_rst(1'b0);
        chk("boot ext", 32'h0000_0001, 32'(boot));
        rd("chip ext", CC, 8'h02, 8'hFF);
        rd("aux ext", AX, 8'hC0, 8'hFF);
        $display("Test pin reset done");
        ta_wr(WD, 8'h80);
        tick_on <= 1'b1;
        repeat (240) @(posedge clk);
        ta_wr(WD, 8'hC0);
        repeat (300) @(posedge clk);
        chk("no expiry", 32'h0000_0000, 32'(ctrl.core_reset));
        wait_rst(1'b1);
        tick_on <= 1'b0;
        wait_rst(1'b0);
        rd("wd flag", WD, 8'h08, 8'h08);
        rd("aux wd", AX, 8'hC0, 8'hFF);
        $display("Test watchdog reset done");
        oth <= 1'b1;
        @(posedge clk);
        oth <= 1'b0;
        wait_rst(1'b1);
        wait_rst(1'b0);
        rd("wd kept", WD, 8'h08, 8'h08);
        ta_wr(WD, 8'h00);
        rd("wd cleared", WD, 8'h00, 8'h08);
        $display("Test other reset done");
        conclude();
    end
endmodule
